// >>> opa_regs.vh
// Purpose: constants for the optical power alarm threshold bank
// Assumes: byte-wide registers on a two-wire serial target
// Notes: definitions only
`ifndef OPA_REGS_VH
`define OPA_REGS_VH

// =====================================================================
// target address and register offsets
`define OPA_DEV_ADDR 7'h51
`define OPA_TX_FLOOR_HI_OFS 8'h1A
`define OPA_TX_FLOOR_LO_OFS 8'h1B
`define OPA_RX_CEIL_HI_OFS 8'h20
`define OPA_RX_CEIL_LO_OFS 8'h21
`define OPA_RX_FLOOR_HI_OFS 8'h22
`define OPA_RX_FLOOR_LO_OFS 8'h23

// =====================================================================
// reset values and fill for unmapped reads
`define OPA_THRESH_RST 8'h00
`define OPA_UNMAPPED_RD 8'h00

// =====================================================================
// scaling of one count of a power high byte, in nanowatts
`define OPA_POWER_LSB_NW 25600

// =====================================================================
// comparison sense for the alarm comparator
`define OPA_CMP_BELOW 1'b0
`define OPA_CMP_ABOVE 1'b1

`endif

// >>> opa_byte_reg.v
// Purpose: one byte-wide threshold register
// Assumes: synchronous active-high reset
// Notes: all bits read/write
`timescale 1ns/1ns
`include "opa_regs.vh"

module opa_byte_reg (
  input wire ref_clk, // system clock
  input wire rst, // synchronous reset
  input wire wrEn, // write strobe
  input wire [7:0] wrData, // byte to store
  output reg [7:0] q_r // stored byte
);

  always @(posedge ref_clk) begin
    if (rst) begin
      q_r <= `OPA_THRESH_RST;
    end else if (wrEn) begin
      q_r <= wrData;
    end
  end

endmodule

// >>> opa_alarm_cmp.v
// Purpose: raw high-byte comparison producing one alarm flag
// Assumes: measurement strobe marks a fresh result
// Notes: flag follows the latest measurement
`timescale 1ns/1ns
`include "opa_regs.vh"

module opa_alarm_cmp #(
  parameter [0:0] SENSE = `OPA_CMP_ABOVE // above or below the limit
) (
  input wire ref_clk, // system clock
  input wire rst, // synchronous reset
  input wire measStb, // new measurement pulse
  input wire [7:0] measHi, // measurement high byte
  input wire [7:0] limitHi, // threshold high byte
  output reg flag_r // alarm flag
);

  wire hit;

  assign hit = (SENSE == `OPA_CMP_ABOVE) ? (measHi > limitHi) : (measHi < limitHi);

  always @(posedge ref_clk) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (measStb) begin
      flag_r <= hit; // see (R11)
    end
  end

endmodule

// >>> opa_thresholds.v
// Purpose: optical power alarm threshold bank behind a two-wire target
// Assumes: scl and sda inputs synchronous to ref_clk, scl far slower
// Notes: sda is open drain, output enable low while pulling low
//
// Function
// (R1) tx floor alarm set when tx measurement high byte is below tx floor high byte
// (R2) rx ceiling alarm set when rx measurement high byte exceeds ceiling high byte
// (R3) rx floor alarm set when rx measurement high byte is below floor high byte
// (R4) low threshold bytes are stored but never used in comparisons
// (R5) one count of rx threshold high byte equals 25.6 microwatts
// (R6) each high/low byte pair is one unsigned 16-bit value, high byte upper
// (R7) thresholds compared as raw values without calibration
// (R8) all threshold bits read/write, reset to zero
// (R9) registers reached at seven-bit target address 1010001
// (R10) host should program low threshold bytes to zero
// (R11) all comparisons re-evaluated on every new measurement
`timescale 1ns/1ns
`include "opa_regs.vh"

module opa_thresholds (
  input wire ref_clk, // 10 MHz system clock
  input wire rst, // synchronous reset, active high
  input wire sclIn, // serial clock from host
  input wire sdaIn, // serial data level on the wire
  output reg sdaOut_r, // serial data drive value, always low
  output reg sdaOe_n_r, // low while pulling sda low
  input wire measStb, // pulse: new power measurement
  input wire [7:0] transmitPowerMeasHi, // tx power measurement high byte
  input wire [7:0] receivePowerMeasHi, // rx power measurement high byte
  output wire txFloorAlarm_r, // tx power below floor
  output wire rxCeilingAlarm_r, // rx power above ceiling
  output wire rxFloorAlarm_r // rx power below floor
);

  // ===================================================================
  // bus states
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_AACK = 7'h04;
  localparam [6:0] S_WR = 7'h08;
  localparam [6:0] S_WACK = 7'h10;
  localparam [6:0] S_RD = 7'h20;
  localparam [6:0] S_RACK = 7'h40;

  reg [6:0] state_r;
  reg sclQ_r;
  reg sdaQ_r;
  reg [2:0] bitCnt_r;
  reg byteDone_r;
  reg [7:0] shift_r;
  reg [7:0] ptr_r;
  reg rw_r;
  reg firstByte_r;
  reg masterAck_r;
  reg wrStb_r;
  reg [7:0] wrAddr_r;
  reg [7:0] wrData_r;
  reg [7:0] rdByte;

  wire sclRise;
  wire sclFall;
  wire startCond;
  wire stopCond;
  wire [7:0] txFloorHi;
  wire [7:0] txFloorLo;
  wire [7:0] rxCeilHi;
  wire [7:0] rxCeilLo;
  wire [7:0] rxFloorHi;
  wire [7:0] rxFloorLo;

  assign sclRise = sclIn & ~sclQ_r;
  assign sclFall = ~sclIn & sclQ_r;
  assign startCond = sclIn & sclQ_r & sdaQ_r & ~sdaIn;
  assign stopCond = sclIn & sclQ_r & ~sdaQ_r & sdaIn;

  // ===================================================================
  // threshold registers
  opa_byte_reg uTxFloorHi (
    .ref_clk(ref_clk),
    .rst(rst),
    .wrEn(wrStb_r && wrAddr_r == `OPA_TX_FLOOR_HI_OFS), // see (R8)
    .wrData(wrData_r),
    .q_r(txFloorHi)
  );

  opa_byte_reg uTxFloorLo (
    .ref_clk(ref_clk),
    .rst(rst),
    .wrEn(wrStb_r && wrAddr_r == `OPA_TX_FLOOR_LO_OFS), // see (R8)
    .wrData(wrData_r),
    .q_r(txFloorLo)
  );

  opa_byte_reg uRxCeilHi (
    .ref_clk(ref_clk),
    .rst(rst),
    .wrEn(wrStb_r && wrAddr_r == `OPA_RX_CEIL_HI_OFS), // see (R8)
    .wrData(wrData_r),
    .q_r(rxCeilHi)
  );

  opa_byte_reg uRxCeilLo (
    .ref_clk(ref_clk),
    .rst(rst),
    .wrEn(wrStb_r && wrAddr_r == `OPA_RX_CEIL_LO_OFS), // see (R8)
    .wrData(wrData_r),
    .q_r(rxCeilLo)
  );

  opa_byte_reg uRxFloorHi (
    .ref_clk(ref_clk),
    .rst(rst),
    .wrEn(wrStb_r && wrAddr_r == `OPA_RX_FLOOR_HI_OFS), // see (R8)
    .wrData(wrData_r),
    .q_r(rxFloorHi)
  );

  opa_byte_reg uRxFloorLo (
    .ref_clk(ref_clk),
    .rst(rst),
    .wrEn(wrStb_r && wrAddr_r == `OPA_RX_FLOOR_LO_OFS), // see (R8)
    .wrData(wrData_r),
    .q_r(rxFloorLo)
  );

  // ===================================================================
  // read mux, pair layout high:low
  always @* begin
    case (ptr_r)
      `OPA_TX_FLOOR_HI_OFS: rdByte = txFloorHi; // see (R6)
      `OPA_TX_FLOOR_LO_OFS: rdByte = txFloorLo;
      `OPA_RX_CEIL_HI_OFS: rdByte = rxCeilHi;
      `OPA_RX_CEIL_LO_OFS: rdByte = rxCeilLo;
      `OPA_RX_FLOOR_HI_OFS: rdByte = rxFloorHi;
      `OPA_RX_FLOOR_LO_OFS: rdByte = rxFloorLo;
      default: rdByte = `OPA_UNMAPPED_RD;
    endcase
  end

  // ===================================================================
  // alarm comparators: raw high bytes only, low bytes never looked at
  opa_alarm_cmp #(.SENSE(`OPA_CMP_BELOW)) uTxFloorCmp (
    .ref_clk(ref_clk),
    .rst(rst),
    .measStb(measStb),
    .measHi(transmitPowerMeasHi), // see (R1) (R4) (R7)
    .limitHi(txFloorHi),
    .flag_r(txFloorAlarm_r)
  );

  // one count of either rx limit is OPA_POWER_LSB_NW, same as measurement
  opa_alarm_cmp #(.SENSE(`OPA_CMP_ABOVE)) uRxCeilCmp (
    .ref_clk(ref_clk),
    .rst(rst),
    .measStb(measStb),
    .measHi(receivePowerMeasHi), // see (R2) (R5) (R7)
    .limitHi(rxCeilHi),
    .flag_r(rxCeilingAlarm_r)
  );

  opa_alarm_cmp #(.SENSE(`OPA_CMP_BELOW)) uRxFloorCmp (
    .ref_clk(ref_clk),
    .rst(rst),
    .measStb(measStb),
    .measHi(receivePowerMeasHi), // see (R3) (R4) (R5)
    .limitHi(rxFloorHi),
    .flag_r(rxFloorAlarm_r)
  );

  // ===================================================================
  // two-wire target
  always @(posedge ref_clk) begin
    if (rst) begin
      state_r <= S_IDLE;
      sclQ_r <= 1'b1;
      sdaQ_r <= 1'b1;
      bitCnt_r <= 3'h0;
      byteDone_r <= 1'b0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      firstByte_r <= 1'b0;
      masterAck_r <= 1'b0;
      wrStb_r <= 1'b0;
      wrAddr_r <= 8'h00;
      wrData_r <= 8'h00;
      sdaOut_r <= 1'b0;
      sdaOe_n_r <= 1'b1;
    end else begin
      sclQ_r <= sclIn;
      sdaQ_r <= sdaIn;
      wrStb_r <= 1'b0;
      if (startCond) begin
        state_r <= S_ADDR;
        bitCnt_r <= 3'h0;
        byteDone_r <= 1'b0;
        sdaOe_n_r <= 1'b1;
      end else if (stopCond) begin
        state_r <= S_IDLE;
        byteDone_r <= 1'b0;
        sdaOe_n_r <= 1'b1;
      end else begin
        case (state_r)
          S_IDLE: begin
            sdaOe_n_r <= 1'b1;
          end
          S_ADDR, S_WR: begin
            if (sclRise) begin
              shift_r <= {shift_r[6:0], sdaIn};
              bitCnt_r <= bitCnt_r + 3'h1;
              if (bitCnt_r == 3'h7) begin
                byteDone_r <= 1'b1;
              end
            end else if (sclFall && byteDone_r) begin
              byteDone_r <= 1'b0;
              if (state_r == S_ADDR) begin
                if (shift_r[7:1] == `OPA_DEV_ADDR) begin // see (R9)
                  sdaOe_n_r <= 1'b0;
                  rw_r <= shift_r[0];
                  state_r <= S_AACK;
                end else begin
                  state_r <= S_IDLE;
                end
              end else begin
                sdaOe_n_r <= 1'b0;
                state_r <= S_WACK;
                if (firstByte_r) begin
                  ptr_r <= shift_r;
                  firstByte_r <= 1'b0;
                end else begin
                  wrStb_r <= 1'b1;
                  wrAddr_r <= ptr_r;
                  wrData_r <= shift_r;
                  ptr_r <= ptr_r + 8'h01;
                end
              end
            end
          end
          S_AACK: begin
            if (sclFall) begin
              bitCnt_r <= 3'h0;
              if (rw_r) begin
                state_r <= S_RD;
                sdaOe_n_r <= rdByte[7];
                shift_r <= {rdByte[6:0], 1'b0};
              end else begin
                state_r <= S_WR;
                sdaOe_n_r <= 1'b1;
                firstByte_r <= 1'b1;
              end
            end
          end
          S_WACK: begin
            if (sclFall) begin
              sdaOe_n_r <= 1'b1;
              state_r <= S_WR;
            end
          end
          S_RD: begin
            if (sclRise) begin
              bitCnt_r <= bitCnt_r + 3'h1;
              if (bitCnt_r == 3'h7) begin
                byteDone_r <= 1'b1;
              end
            end else if (sclFall) begin
              if (byteDone_r) begin
                byteDone_r <= 1'b0;
                sdaOe_n_r <= 1'b1;
                ptr_r <= ptr_r + 8'h01;
                state_r <= S_RACK;
              end else begin
                sdaOe_n_r <= shift_r[7];
                shift_r <= {shift_r[6:0], 1'b0};
              end
            end
          end
          S_RACK: begin
            if (sclRise) begin
              masterAck_r <= ~sdaIn;
            end else if (sclFall) begin
              if (masterAck_r) begin
                state_r <= S_RD;
                bitCnt_r <= 3'h0;
                sdaOe_n_r <= rdByte[7];
                shift_r <= {rdByte[6:0], 1'b0};
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
          default: begin
            state_r <= S_IDLE;
            sdaOe_n_r <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

// >>> opa_thresholds_props.sv
// Purpose: port checker for the threshold bank
// Assumes: one clock, synchronous reset
// Notes: bound after the module
`timescale 1ns/1ns
module opa_thresholds_props (
  input wire ref_clk, // clock
  input wire rst, // reset
  input wire sclIn, // serial clock
  input wire sdaIn, // sda level
  input wire sdaOut_r, // sda drive value
  input wire sdaOe_n_r, // sda enable
  input wire measStb, // new measurement
  input wire [7:0] transmitPowerMeasHi, // tx meas
  input wire [7:0] receivePowerMeasHi, // rx meas
  input wire txFloorAlarm_r, // tx floor flag
  input wire rxCeilingAlarm_r, // rx ceiling flag
  input wire rxFloorAlarm_r // rx floor flag
);
  // ====================
  // properties
  wire [2:0] flags = {txFloorAlarm_r, rxCeilingAlarm_r, rxFloorAlarm_r};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  flag_hold_a: assert property (!measStb |=> $stable(flags))
    else $error("flags moved without strobe");
  reset_clear_a: assert property ($fell(rst) |-> flags == 3'h0 && sdaOe_n_r)
    else $error("flags or sda not idle after reset");
  tx_top_a: assert property (
    measStb && transmitPowerMeasHi == 8'hFF |=> !txFloorAlarm_r)
    else $error("tx floor flag at full scale");
  rx_top_a: assert property (
    measStb && receivePowerMeasHi == 8'hFF |=> !rxFloorAlarm_r)
    else $error("rx floor flag at full scale");
  rx_zero_a: assert property (
    measStb && receivePowerMeasHi == 8'h00 |=> !rxCeilingAlarm_r)
    else $error("rx ceiling flag at zero");
  sda_low_a: assert property (sdaOut_r == 1'h0)
    else $error("sda driven high");
  ack_edge_a: assert property ($changed(sdaOe_n_r) |-> !sclIn && !$past(sclIn))
    else $error("sda moved while scl high");
  ack_hold_a: assert property ($rose(sclIn) |=> $stable(sdaOe_n_r) [*3])
    else $error("sda not held in scl high");
  cover property (measStb ##1 txFloorAlarm_r);
  cover property (rxCeilingAlarm_r && rxFloorAlarm_r);
  cover property ($fell(sdaOe_n_r));
endmodule

bind opa_thresholds opa_thresholds_props opa_thresholds_props_inst (
  .ref_clk(ref_clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut_r(sdaOut_r), .sdaOe_n_r(sdaOe_n_r), .measStb(measStb),
  .transmitPowerMeasHi(transmitPowerMeasHi), .receivePowerMeasHi(receivePowerMeasHi),
  .txFloorAlarm_r(txFloorAlarm_r), .rxCeilingAlarm_r(rxCeilingAlarm_r),
  .rxFloorAlarm_r(rxFloorAlarm_r));

// >>> opa_host_model.sv
// Purpose: two-wire host controller model
// Assumes: bus phases of four clocks
// Notes: sda open drain, released level high
`timescale 1ns/1ns
`include "opa_regs.vh"
module opa_host_model (
  input wire ref_clk, // system clock
  input wire sdaLine, // resolved sda level
  output reg scl = 1'h1, // serial clock
  output reg sdaHigh = 1'h1 // low pulls sda down
);
  // ====================
  // bus phases
  task step(input s, input d);
    @(posedge ref_clk);
    scl <= s;
    sdaHigh <= d;
    repeat (3) @(posedge ref_clk);
  endtask
  task bitx(input b, output r);
    step(1'h0, b);
    step(1'h1, b);
    r = sdaLine;
    step(1'h0, b);
  endtask
  task xbyte(input [7:0] tx, input ackIn, output [7:0] rx, output ackOut);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      bitx(tx[i], rx[i]);
    end
    bitx(ackIn, ackOut);
  endtask
  task start;
    step(1'h0, 1'h1);
    step(1'h1, 1'h1);
    step(1'h1, 1'h0);
    step(1'h0, 1'h0);
  endtask
  task stop;
    step(1'h0, 1'h0);
    step(1'h1, 1'h0);
    step(1'h1, 1'h1);
  endtask
  // address byte names the target
  task regWrite(input [6:0] adr, input [7:0] ofs, input [7:0] d, output [2:0] ack);
    reg [7:0] rx;
    start;
    xbyte({adr, 1'h0}, 1'h1, rx, ack[2]);
    xbyte(ofs, 1'h1, rx, ack[1]);
    xbyte(d, 1'h1, rx, ack[0]);
    stop;
  endtask
  task regRead(input [7:0] ofs, output [7:0] d, output [2:0] ack);
    reg [7:0] rx;
    start;
    xbyte({`OPA_DEV_ADDR, 1'h0}, 1'h1, rx, ack[2]);
    xbyte(ofs, 1'h1, rx, ack[1]);
    start;
    xbyte({`OPA_DEV_ADDR, 1'h1}, 1'h1, rx, ack[0]);
    xbyte(8'hFF, 1'h1, d, rx[0]);
    stop;
  endtask
  // two bytes in one read, host acks the first to go on
  task regReadPair(input [7:0] ofs, output [15:0] d, output [2:0] ack);
    reg [7:0] rx;
    start;
    xbyte({`OPA_DEV_ADDR, 1'h0}, 1'h1, rx, ack[2]);
    xbyte(ofs, 1'h1, rx, ack[1]);
    start;
    xbyte({`OPA_DEV_ADDR, 1'h1}, 1'h1, rx, ack[0]);
    xbyte(8'hFF, 1'h0, d[15:8], rx[0]);
    xbyte(8'hFF, 1'h1, d[7:0], rx[0]);
    stop;
  endtask
endmodule

// >>> opa_thresholds_tb.sv
// Purpose: self-checking bench for the threshold bank
// Assumes: host model drives the two-wire bus
// Notes: rows hold thresholds, measurements, flags
`timescale 1ns/1ns
`include "opa_regs.vh"
module opa_thresholds_tb;
  reg ref_clk;
  reg rst = 1'h1;
  reg measStb = 1'h0;
  reg [7:0] txMeas = 8'h00;
  reg [7:0] rxMeas = 8'h00;
  wire scl;
  wire sdaHigh;
  wire sdaOut;
  wire sdaOe_n;
  wire [2:0] flags;
  wire sdaLine = sdaHigh & (sdaOe_n | sdaOut);
  integer nMismatch = 0;
  integer checkCount = 0;
  integer i;
  reg [2:0] ack;
  reg [7:0] rdv;
  reg [15:0] rdPair;
  reg [47:0] rows [0:4];
  reg [47:0] ofsList = {`OPA_TX_FLOOR_HI_OFS, `OPA_TX_FLOOR_LO_OFS, `OPA_RX_CEIL_HI_OFS,
    `OPA_RX_CEIL_LO_OFS, `OPA_RX_FLOOR_HI_OFS, `OPA_RX_FLOOR_LO_OFS};

  opa_thresholds opa_thresholds_inst (.ref_clk(ref_clk), .rst(rst), .sclIn(scl),
    .sdaIn(sdaLine), .sdaOut_r(sdaOut), .sdaOe_n_r(sdaOe_n), .measStb(measStb),
    .transmitPowerMeasHi(txMeas), .receivePowerMeasHi(rxMeas),
    .txFloorAlarm_r(flags[2]), .rxCeilingAlarm_r(flags[1]), .rxFloorAlarm_r(flags[0]));
  opa_host_model opa_host_model_inst (.ref_clk(ref_clk), .sdaLine(sdaLine),
    .scl(scl), .sdaHigh(sdaHigh));

  // ====================
  // tasks
  task chk(input [7:0] seen, input [7:0] exp);
    checkCount = checkCount + 1;
    if (seen !== exp) begin
      nMismatch = nMismatch + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    opa_host_model_inst.regWrite(`OPA_DEV_ADDR, a, d, ack);
    chk({5'h0, ack}, 8'h00);
  endtask
  task rd(input [7:0] a);
    opa_host_model_inst.regRead(a, rdv, ack);
    chk({5'h0, ack}, 8'h00);
  endtask
  task meas(input [7:0] t, input [7:0] r);
    @(posedge ref_clk);
    txMeas <= t;
    rxMeas <= r;
    measStb <= 1'h1;
    @(posedge ref_clk);
    measStb <= 1'h0;
    @(negedge ref_clk);
  endtask

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    nMismatch = nMismatch + 1;
    conclude;
  end
  initial begin
    rows[0] = 48'h0A1405_0915_06;
    rows[1] = 48'h0A1405_0A14_00;
    rows[2] = 48'h0A1419_0B00_01;
    rows[3] = 48'hFF00FF_FEFE_07;
    rows[4] = 48'h00FF00_FFFF_00;
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    @(negedge ref_clk);
    chk({5'h0, flags}, 8'h00);
    chk({7'h0, sdaOut}, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      rd(ofsList[8 * i +: 8]);
      chk(rdv, `OPA_THRESH_RST);
      wr(ofsList[8 * i +: 8], 8'hFF);
      rd(ofsList[8 * i +: 8]);
      chk(rdv, 8'hFF);
    end
    $display("register access done");
    // low bytes stay at all ones through the rows
    for (i = 0; i < 5; i = i + 1) begin
      wr(`OPA_TX_FLOOR_HI_OFS, rows[i][47:40]);
      wr(`OPA_RX_CEIL_HI_OFS, rows[i][39:32]);
      wr(`OPA_RX_FLOOR_HI_OFS, rows[i][31:24]);
      meas(rows[i][23:16], rows[i][15:8]);
      chk({5'h0, flags}, rows[i][7:0]);
      $display("row %0d done", i);
    end
    // low bytes back to zero, then one pair read with a host ack between bytes
    wr(`OPA_TX_FLOOR_LO_OFS, 8'h00);
    wr(`OPA_RX_CEIL_LO_OFS, 8'h00);
    wr(`OPA_RX_FLOOR_LO_OFS, 8'h00);
    opa_host_model_inst.regReadPair(`OPA_RX_CEIL_HI_OFS, rdPair, ack);
    chk({5'h0, ack}, 8'h00);
    chk(rdPair[15:8], 8'hFF);
    chk(rdPair[7:0], 8'h00);
    $display("pair read done");
    wr(`OPA_RX_CEIL_HI_OFS, 8'h00);
    @(negedge ref_clk);
    chk({5'h0, flags}, 8'h00);
    @(posedge ref_clk);
    measStb <= 1'h1;
    rxMeas <= 8'h00;
    @(posedge ref_clk);
    rxMeas <= 8'h01;
    @(negedge ref_clk);
    chk({5'h0, flags}, 8'h00);
    @(posedge ref_clk);
    measStb <= 1'h0;
    @(negedge ref_clk);
    chk({5'h0, flags}, 8'h02);
    $display("strobe tests done");
    opa_host_model_inst.regWrite(`OPA_DEV_ADDR + 7'h01, `OPA_RX_CEIL_HI_OFS, 8'h77, ack);
    chk({5'h0, ack}, 8'h07);
    rd(`OPA_RX_CEIL_HI_OFS);
    chk(rdv, 8'h00);
    wr(8'h30, 8'h55);
    rd(8'h30);
    chk(rdv, `OPA_UNMAPPED_RD);
    $display("address tests done");
    @(posedge ref_clk);
    rst <= 1'h1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    @(negedge ref_clk);
    chk({5'h0, flags}, 8'h00);
    rd(`OPA_TX_FLOOR_LO_OFS);
    chk(rdv, `OPA_THRESH_RST);
    $display("second reset done");
    conclude;
  end
endmodule
